// ---- rtl/cfa_pkg.sv ----
// constants and types of the flag alu datapath slice
// assumes one 250 MHz clock and a plain register port with 4-bit word index
`default_nettype none
package cfa_pkg;
  // ----------------------------------------------------------------
  // register map (word index)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 4;
  localparam logic [3:0]  REG_ACC   = 4'h0;
  localparam logic [3:0]  REG_B     = 4'h1;
  localparam logic [3:0]  REG_C     = 4'h2;
  localparam logic [3:0]  REG_D     = 4'h3;
  localparam logic [3:0]  REG_E     = 4'h4;
  localparam logic [3:0]  REG_H     = 4'h5;
  localparam logic [3:0]  REG_L     = 4'h6;
  localparam logic [3:0]  REG_SPL   = 4'h7;
  localparam logic [3:0]  REG_SPH   = 4'h8;
  localparam logic [3:0]  REG_FLAGS = 4'h9;
  localparam logic [3:0]  REG_CMD   = 4'hA;
  localparam logic [3:0]  REG_STAT  = 4'hB;
  localparam logic [3:0]  REG_PCL   = 4'hC;
  localparam logic [3:0]  REG_PCH   = 4'hD;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int unsigned FLG_S     = 7;
  localparam int unsigned FLG_Z     = 6;
  localparam int unsigned FLG_A     = 4;
  localparam int unsigned FLG_P     = 2;
  localparam int unsigned FLG_C     = 0;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam int unsigned STS_BUSY  = 0;
  localparam int unsigned STS_HALT  = 1;
  localparam int unsigned STS_HOLD  = 2;
  localparam int unsigned STS_INT   = 3;
  localparam int unsigned STS_TAKEN = 4;
  localparam int unsigned CMD_OP_LSB = 3;
  localparam logic [2:0]  SEL_MEM   = 3'h6;
  localparam logic [2:0]  SEL_ACC   = 3'h7;
  localparam logic [1:0]  PAIR_SP   = 2'h3;
  // ----------------------------------------------------------------
  // timing: clock states per machine cycle
  // ----------------------------------------------------------------
  localparam logic [2:0]  MC1_SHORT = 3'h4;
  localparam logic [2:0]  MC1_LONG  = 3'h5;
  localparam logic [2:0]  MC_BUS    = 3'h3;

  typedef enum logic [4:0] {
    OP_NO_OPERATION   = 5'h00, OP_HALT          = 5'h01, OP_ADD      = 5'h02,
    OP_ADC            = 5'h03, OP_SUB           = 5'h04, OP_SBB      = 5'h05,
    OP_AND            = 5'h06, OP_XOR           = 5'h07, OP_OR       = 5'h08,
    OP_CMP            = 5'h09, OP_INC           = 5'h0A, OP_DEC      = 5'h0B,
    OP_INC_PAIR       = 5'h0C, OP_DEC_PAIR      = 5'h0D, OP_ROT_L    = 5'h0E,
    OP_ROT_R          = 5'h0F, OP_ROT_LC        = 5'h10, OP_ROT_RC   = 5'h11,
    OP_DECIMAL_ADJUST = 5'h12, OP_SET_CARRY     = 5'h13, OP_INVERT_CARRY = 5'h14,
    OP_INVERT_ACC     = 5'h15, OP_PAIR_SWAP     = 5'h16, OP_PORT_IN  = 5'h17,
    OP_PORT_OUT       = 5'h18, OP_JUMP_COND     = 5'h19
  } cfa_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_T1 = 3'h1, ST_T2 = 3'h2, ST_T3 = 3'h3,
    ST_T4 = 3'h4, ST_T5 = 3'h5, ST_WAIT = 3'h6, ST_HOLD_WAIT = 3'h7
  } cfa_state_t;

  typedef enum logic [2:0] {
    MC_NONE = 3'h0, MC_FETCH = 3'h1, MC_MEM_RD = 3'h2,
    MC_MEM_WR = 3'h3, MC_IO_RD = 3'h4, MC_IO_WR = 3'h5
  } cfa_mc_t;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] flg;
  } cfa_alu_t;

  // bus request group towards memory and ports
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        io;
  } cfa_bus_t;

  typedef struct packed {
    cfa_state_t      st;
    logic [2:0]      mc;
    cfa_op_t         op;
    logic [2:0]      sel;
    logic [7:0][7:0] gpr;
    logic [15:0]     sp;
    logic [15:0]     pc;
    logic [7:0]      flg;
    logic [1:0][7:0] tmp;
    logic            busy;
    logic            halted;
    logic            hold_req;
    logic            hold_gnt;
    logic            int_pend;
    logic            taken;
    cfa_bus_t        bus;
    logic [7:0]      rdata;
  } cfa_regs_t;
endpackage
`default_nettype wire

// ---- rtl/cfa_core.sv ----
// execution slice of an 8-bit processor: flags, branch test, special ops
// assumes synchronous inputs, one clock, software issuing one opcode per command
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
// Function
// - sign flag copies bit 7 of a flag-affecting result.
// - zero flag set for zero result, cleared otherwise.
// - parity flag set when result has even count of ones.
// - carry flag marks carry or borrow out of bit 7.
// - auxiliary carry marks carry or borrow from bit 3 into 4.
// - flags change only on flag-affecting operations, else held.
// - branch decisions use only sign, zero, parity and carry.
// - auxiliary carry is never a branch condition, only decimal adjust.
// - operations to set carry, invert carry and invert accumulator.
// - pair swap exchanges two 16-bit pairs without memory access.
// - rotate accumulator left or right, through or around carry.
// - increment/decrement bytes, registers, accumulator, pairs and stack pointer.
// - data are 8-bit integers, bit 7 most significant on bus.
// - instructions are one to three bytes in consecutive locations.
// - first byte address is instruction address; further bytes follow.
// - no-operation only advances program counter; halt stops execution.
// - directly addressed port input and output are offered.
// - hold sampled in T2/wait on entry, and while holding.
// - interrupt stable in last instruction clock is recognised next.
// - machine cycles take three to five states, one to three per instruction.
module cfa_core (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  output logic      [15:0] BUS_ADDR_O,
  output logic      [7:0]  BUS_DATA_O,
  output logic             BUS_DATA_OE_O,
  input  wire logic [7:0]  BUS_DATA_I,
  output logic             BUS_WR_O,
  output logic             BUS_IO_O,
  output logic             DATA_IN_STROBE_O,
  input  wire logic        READY_I,
  input  wire logic        HOLD_I,
  output logic             HOLD_GRANT_O,
  input  wire logic        INT_I,
  output logic             INT_PENDING_O,
  output logic             HALTED_O,
  output logic             BUSY_O
);
  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // sign, zero and parity of a result into a flag byte
  function automatic logic [7:0] szp_f(input logic [7:0] v, input logic [7:0] f);
    logic [7:0] o;
    o = f;
    o[cfa_pkg::FLG_S] = v[7];
    o[cfa_pkg::FLG_Z] = (v == 8'h00);
    o[cfa_pkg::FLG_P] = ~^v;
    return o;
  endfunction

  function automatic cfa_pkg::cfa_alu_t alu_f(input cfa_pkg::cfa_op_t op,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
    cfa_pkg::cfa_alu_t r;
    logic [8:0] w;
    logic [4:0] nb;
    logic       ci;
    logic       lo;
    logic       hi;
    r.res = a;
    r.flg = f;
    ci = ((op == cfa_pkg::OP_ADC) || (op == cfa_pkg::OP_SBB)) & f[cfa_pkg::FLG_C];
    w  = 9'h000;
    nb = 5'h00;
    lo = 1'b0;
    hi = 1'b0;
    case (op)
      cfa_pkg::OP_ADD, cfa_pkg::OP_ADC: begin
        w  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        nb = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        r.res = w[7:0];
        r.flg = szp_f(w[7:0], f);
        r.flg[cfa_pkg::FLG_C] = w[8];
        r.flg[cfa_pkg::FLG_A] = nb[4];
      end
      cfa_pkg::OP_SUB, cfa_pkg::OP_SBB, cfa_pkg::OP_CMP: begin
        w  = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        nb = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        r.res = (op == cfa_pkg::OP_CMP) ? a : w[7:0];
        r.flg = szp_f(w[7:0], f);
        r.flg[cfa_pkg::FLG_C] = w[8];
        r.flg[cfa_pkg::FLG_A] = nb[4];
      end
      cfa_pkg::OP_AND, cfa_pkg::OP_XOR, cfa_pkg::OP_OR: begin
        r.res = (op == cfa_pkg::OP_AND) ? (a & b) :
                (op == cfa_pkg::OP_XOR) ? (a ^ b) : (a | b);
        r.flg = szp_f(r.res, f);
        r.flg[cfa_pkg::FLG_C] = 1'b0;
        r.flg[cfa_pkg::FLG_A] = 1'b0;
      end
      // carry is left alone by single-byte step operations
      cfa_pkg::OP_INC, cfa_pkg::OP_DEC: begin
        r.res = (op == cfa_pkg::OP_INC) ? a + 8'h01 : a - 8'h01;
        r.flg = szp_f(r.res, f);
        r.flg[cfa_pkg::FLG_A] = (op == cfa_pkg::OP_INC) ? (a[3:0] == 4'hF)
                                                        : (a[3:0] == 4'h0);
      end
      cfa_pkg::OP_ROT_L: begin
        r.res = {a[6:0], f[cfa_pkg::FLG_C]};
        r.flg[cfa_pkg::FLG_C] = a[7];
      end
      cfa_pkg::OP_ROT_R: begin
        r.res = {f[cfa_pkg::FLG_C], a[7:1]};
        r.flg[cfa_pkg::FLG_C] = a[0];
      end
      cfa_pkg::OP_ROT_LC: begin
        r.res = {a[6:0], a[7]};
        r.flg[cfa_pkg::FLG_C] = a[7];
      end
      cfa_pkg::OP_ROT_RC: begin
        r.res = {a[0], a[7:1]};
        r.flg[cfa_pkg::FLG_C] = a[0];
      end
      // low nibble first, its carry feeds the high nibble test
      cfa_pkg::OP_DECIMAL_ADJUST: begin
        lo = (a[3:0] > 4'h9) || f[cfa_pkg::FLG_A];
        w  = {1'b0, a} + (lo ? 9'h006 : 9'h000);
        hi = (w[7:4] > 4'h9) || w[8] || f[cfa_pkg::FLG_C];
        r.res = w[7:0] + (hi ? 8'h60 : 8'h00);
        r.flg = szp_f(r.res, f);
        r.flg[cfa_pkg::FLG_C] = hi;
        r.flg[cfa_pkg::FLG_A] = lo && (a[3:0] > 4'h9);
      end
      cfa_pkg::OP_SET_CARRY:    r.flg[cfa_pkg::FLG_C] = 1'b1;
      cfa_pkg::OP_INVERT_CARRY: r.flg[cfa_pkg::FLG_C] = ~f[cfa_pkg::FLG_C];
      cfa_pkg::OP_INVERT_ACC:   r.res = ~a;
      default: r.res = a;
    endcase
    return r;
  endfunction

  // instruction length in bytes
  function automatic logic [15:0] len_f(input cfa_pkg::cfa_op_t op, input logic [2:0] sel);
    if (op == cfa_pkg::OP_JUMP_COND) begin
      return 16'h0003;
    end else if ((op == cfa_pkg::OP_PORT_IN) || (op == cfa_pkg::OP_PORT_OUT) ||
                 (is_alu_f(op) && (sel == cfa_pkg::SEL_MEM))) begin
      return 16'h0002;
    end
    return 16'h0001;
  endfunction

  function automatic logic is_alu_f(input cfa_pkg::cfa_op_t op);
    return (op >= cfa_pkg::OP_ADD) && (op <= cfa_pkg::OP_CMP);
  endfunction

  function automatic logic is_mem_step_f(input cfa_pkg::cfa_op_t op, input logic [2:0] sel);
    return ((op == cfa_pkg::OP_INC) || (op == cfa_pkg::OP_DEC)) && (sel == cfa_pkg::SEL_MEM);
  endfunction

  // kind of bus transfer done in a given machine cycle
  function automatic cfa_pkg::cfa_mc_t kind_f(input cfa_pkg::cfa_op_t op,
      input logic [2:0] sel, input logic [2:0] mc);
    if (mc == 3'h1) begin
      return cfa_pkg::MC_NONE;
    end else if (is_mem_step_f(op, sel)) begin
      return (mc == 3'h2) ? cfa_pkg::MC_MEM_RD : cfa_pkg::MC_MEM_WR;
    end else if ((op == cfa_pkg::OP_PORT_IN) && (mc == 3'h3)) begin
      return cfa_pkg::MC_IO_RD;
    end else if ((op == cfa_pkg::OP_PORT_OUT) && (mc == 3'h3)) begin
      return cfa_pkg::MC_IO_WR;
    end
    return cfa_pkg::MC_FETCH;
  endfunction

  // machine cycles per instruction
  function automatic logic [2:0] nmc_f(input cfa_pkg::cfa_op_t op, input logic [2:0] sel);
    if (is_mem_step_f(op, sel) || (op == cfa_pkg::OP_PORT_IN) ||
        (op == cfa_pkg::OP_PORT_OUT)) begin
      return 3'h3;
    end
    return 3'(len_f(op, sel));
  endfunction

  function automatic logic [15:0] pair_f(input cfa_pkg::cfa_regs_t s, input logic [1:0] p);
    if (p == cfa_pkg::PAIR_SP) begin
      return s.sp;
    end
    return {s.gpr[{p, 1'b0}], s.gpr[{p, 1'b1}]};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cfa_pkg::cfa_regs_t q;
  cfa_pkg::cfa_regs_t d;
  cfa_pkg::cfa_mc_t   kind;
  cfa_pkg::cfa_alu_t  r;
  logic [2:0]         mc_len;
  logic               mc_end;
  logic               instr_end;
  logic               cmd_go;
  logic               cond;
  logic [7:0]         src;
  logic [15:0]        pv;

  // decode of the current machine cycle
  always_comb begin
    kind   = kind_f(q.op, q.sel, q.mc);
    mc_len = (q.mc == 3'h1) ? (((q.op == cfa_pkg::OP_INC_PAIR) ||
             (q.op == cfa_pkg::OP_DEC_PAIR) || ((q.op == cfa_pkg::OP_INC ||
             q.op == cfa_pkg::OP_DEC) && q.sel != cfa_pkg::SEL_MEM)) ?
             cfa_pkg::MC1_LONG : cfa_pkg::MC1_SHORT) : cfa_pkg::MC_BUS;
    mc_end = ((q.st == cfa_pkg::ST_T3) && (mc_len == cfa_pkg::MC_BUS)) ||
             ((q.st == cfa_pkg::ST_T4) && (mc_len == cfa_pkg::MC1_SHORT)) ||
             (q.st == cfa_pkg::ST_T5);
    instr_end = mc_end && (q.mc == nmc_f(q.op, q.sel));
    src = (q.sel != cfa_pkg::SEL_MEM) ? q.gpr[q.sel] : (is_alu_f(q.op) ? BUS_DATA_I : q.tmp[0]);
    r   = alu_f(q.op, (((q.op == cfa_pkg::OP_INC) || (q.op == cfa_pkg::OP_DEC)) ? src :
                q.gpr[cfa_pkg::SEL_ACC]), src, q.flg);
    pv = pair_f(q, q.sel[2:1]) + ((q.op == cfa_pkg::OP_INC_PAIR) ? 16'h0001 : 16'hFFFF);
    // only the four testable flags can steer a branch
    case (q.sel[2:1])
      2'h0:    cond = q.flg[cfa_pkg::FLG_Z];
      2'h1:    cond = q.flg[cfa_pkg::FLG_C];
      2'h2:    cond = q.flg[cfa_pkg::FLG_P];
      default: cond = q.flg[cfa_pkg::FLG_S];
    endcase
    cond = cond ~^ q.sel[0];
    cmd_go = WR_I && (ADDR_I == cfa_pkg::REG_CMD) && (q.st == cfa_pkg::ST_IDLE) &&
             !q.halted;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // register port; read data valid only in the cycle after the strobe
    d.rdata = 8'h00;
    if (RD_I) begin
      case (ADDR_I)
        cfa_pkg::REG_ACC:   d.rdata = q.gpr[cfa_pkg::SEL_ACC];
        cfa_pkg::REG_B, cfa_pkg::REG_C, cfa_pkg::REG_D, cfa_pkg::REG_E,
        cfa_pkg::REG_H, cfa_pkg::REG_L: d.rdata = q.gpr[ADDR_I[2:0] - 3'h1];
        cfa_pkg::REG_SPL:   d.rdata = q.sp[7:0];
        cfa_pkg::REG_SPH:   d.rdata = q.sp[15:8];
        cfa_pkg::REG_FLAGS: d.rdata = q.flg;
        cfa_pkg::REG_STAT:  d.rdata = {3'h0, q.taken, q.int_pend, q.hold_gnt,
                                       q.halted, q.busy};
        cfa_pkg::REG_PCL:   d.rdata = q.pc[7:0];
        cfa_pkg::REG_PCH:   d.rdata = q.pc[15:8];
        default:            d.rdata = 8'h00;
      endcase
    end
    // writes to state are refused while an instruction is in flight
    if (WR_I && (q.st == cfa_pkg::ST_IDLE)) begin
      case (ADDR_I)
        cfa_pkg::REG_ACC:   d.gpr[cfa_pkg::SEL_ACC] = WDATA_I;
        cfa_pkg::REG_B, cfa_pkg::REG_C, cfa_pkg::REG_D, cfa_pkg::REG_E,
        cfa_pkg::REG_H, cfa_pkg::REG_L: d.gpr[ADDR_I[2:0] - 3'h1] = WDATA_I;
        cfa_pkg::REG_SPL:   d.sp[7:0] = WDATA_I;
        cfa_pkg::REG_SPH:   d.sp[15:8] = WDATA_I;
        cfa_pkg::REG_FLAGS: d.flg = WDATA_I;
        cfa_pkg::REG_PCL:   d.pc[7:0] = WDATA_I;
        cfa_pkg::REG_PCH:   d.pc[15:8] = WDATA_I;
        default:            d.flg = q.flg;
      endcase
    end
    if (WR_I && (ADDR_I == cfa_pkg::REG_STAT) && WDATA_I[cfa_pkg::STS_INT]) begin
      d.int_pend = 1'b0;
    end
    if (cmd_go) begin
      d.op   = cfa_pkg::cfa_op_t'(WDATA_I[7:cfa_pkg::CMD_OP_LSB]);
      d.sel  = WDATA_I[2:0];
      d.busy = 1'b1;
      d.mc   = 3'h1;
      d.st   = cfa_pkg::ST_T1;
    end
    // sequencer
    case (q.st)
      cfa_pkg::ST_IDLE: begin
        if (!cmd_go && HOLD_I) begin
          d.st       = cfa_pkg::ST_HOLD_WAIT;
          d.hold_gnt = 1'b1;
        end
      end
      // address and write data settle one state ahead of the strobes
      cfa_pkg::ST_T1: begin
        d.st = cfa_pkg::ST_T2;
        d.bus.io = (kind == cfa_pkg::MC_IO_RD) || (kind == cfa_pkg::MC_IO_WR);
        case (kind)
          cfa_pkg::MC_FETCH:  d.bus.addr = q.pc + {13'h0000, q.mc - 3'h1};
          cfa_pkg::MC_MEM_RD, cfa_pkg::MC_MEM_WR: d.bus.addr = pair_f(q, 2'h2);
          cfa_pkg::MC_IO_RD, cfa_pkg::MC_IO_WR:   d.bus.addr = {q.tmp[0], q.tmp[0]};
          default:            d.bus.addr = q.bus.addr;
        endcase
        d.bus.dout = (kind == cfa_pkg::MC_IO_WR) ? q.gpr[cfa_pkg::SEL_ACC] : r.res;
      end
      cfa_pkg::ST_T2, cfa_pkg::ST_WAIT: begin
        if (HOLD_I) begin
          d.hold_req = 1'b1;
        end
        d.st = READY_I ? cfa_pkg::ST_T3 : cfa_pkg::ST_WAIT;
      end
      cfa_pkg::ST_T3: begin
        d.st = cfa_pkg::ST_T4;
        if ((kind == cfa_pkg::MC_FETCH) || (kind == cfa_pkg::MC_MEM_RD) ||
            (kind == cfa_pkg::MC_IO_RD)) begin
          d.tmp[q.mc == 3'h3] = BUS_DATA_I;
        end
      end
      cfa_pkg::ST_T4: d.st = cfa_pkg::ST_T5;
      cfa_pkg::ST_T5: d.st = cfa_pkg::ST_IDLE;
      cfa_pkg::ST_HOLD_WAIT: begin
        if (!HOLD_I) begin
          d.hold_gnt = 1'b0;
          d.st = q.busy ? cfa_pkg::ST_T1 : cfa_pkg::ST_IDLE;
        end
      end
      default: d.st = cfa_pkg::ST_IDLE;
    endcase
    // end of a machine cycle; a pending hold is granted between cycles
    if (mc_end) begin
      d.mc = q.mc + 3'h1;
      if (d.hold_req) begin
        d.st       = cfa_pkg::ST_HOLD_WAIT;
        d.hold_gnt = 1'b1;
        d.hold_req = 1'b0;
      end else begin
        d.st = instr_end ? cfa_pkg::ST_IDLE : cfa_pkg::ST_T1;
      end
    end
    // commit at the last clock state of the instruction
    if (instr_end) begin
      d.busy = 1'b0;
      d.mc   = 3'h1;
      d.flg  = r.flg;
      d.pc   = q.pc + len_f(q.op, q.sel);
      case (q.op)
        cfa_pkg::OP_ADD, cfa_pkg::OP_ADC, cfa_pkg::OP_SUB, cfa_pkg::OP_SBB,
        cfa_pkg::OP_AND, cfa_pkg::OP_XOR, cfa_pkg::OP_OR, cfa_pkg::OP_ROT_L,
        cfa_pkg::OP_ROT_R, cfa_pkg::OP_ROT_LC, cfa_pkg::OP_ROT_RC,
        cfa_pkg::OP_DECIMAL_ADJUST, cfa_pkg::OP_INVERT_ACC:
          d.gpr[cfa_pkg::SEL_ACC] = r.res;
        cfa_pkg::OP_INC, cfa_pkg::OP_DEC: begin
          if (q.sel != cfa_pkg::SEL_MEM) begin
            d.gpr[q.sel] = r.res;
          end
        end
        cfa_pkg::OP_INC_PAIR, cfa_pkg::OP_DEC_PAIR: begin
          if (q.sel[2:1] == cfa_pkg::PAIR_SP) begin
            d.sp = pv;
          end else begin
            {d.gpr[{q.sel[2:1], 1'b0}], d.gpr[{q.sel[2:1], 1'b1}]} = pv;
          end
        end
        cfa_pkg::OP_PAIR_SWAP: begin
          {d.gpr[2], d.gpr[3]} = {q.gpr[4], q.gpr[5]};
          {d.gpr[4], d.gpr[5]} = {q.gpr[2], q.gpr[3]};
        end
        cfa_pkg::OP_PORT_IN: d.gpr[cfa_pkg::SEL_ACC] = d.tmp[1];
        cfa_pkg::OP_JUMP_COND: begin
          d.taken = cond;
          if (cond) begin
            d.pc = {d.tmp[1], q.tmp[0]};                       // high byte lands on this edge
          end
        end
        cfa_pkg::OP_HALT: d.halted = 1'b1;
        default: d.taken = q.taken;
      endcase
    end
    // interrupt seen in the last state, or at any state while halted; set beats clear
    if ((instr_end || q.halted) && INT_I) begin
      d.int_pend = 1'b1;
      d.halted   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q     <= '0;
      q.flg <= cfa_pkg::FLAGS_RST;
    end else begin
      q <= d;
    end
  end

  // strobes decoded from state; data and address straight from flops
  assign RDATA_O          = q.rdata;
  assign BUS_ADDR_O       = q.bus.addr;
  assign BUS_DATA_O       = q.bus.dout;
  assign BUS_IO_O         = q.bus.io;
  assign BUS_DATA_OE_O    = ((kind == cfa_pkg::MC_MEM_WR) || (kind == cfa_pkg::MC_IO_WR)) &&
                            ((q.st == cfa_pkg::ST_T2) || (q.st == cfa_pkg::ST_WAIT) ||
                             (q.st == cfa_pkg::ST_T3));
  assign BUS_WR_O         = BUS_DATA_OE_O && (q.st == cfa_pkg::ST_T3);
  assign DATA_IN_STROBE_O = (q.st == cfa_pkg::ST_T3) && ((kind == cfa_pkg::MC_FETCH) ||
                            (kind == cfa_pkg::MC_MEM_RD) || (kind == cfa_pkg::MC_IO_RD));
  assign HOLD_GRANT_O     = q.hold_gnt;
  assign INT_PENDING_O    = q.int_pend;
  assign HALTED_O         = q.halted;
  assign BUSY_O           = q.busy;
endmodule
`default_nettype wire

// ---- verif/cfa_props.sv ----
// assertions on the flag alu slice ports
// assumes one clock and an async high reset
`default_nettype none
module cfa_props (
  input wire logic       CLK_I, RST_I, WR_I, RD_I, HOLD_I, INT_I, BUSY_O, HALTED_O,
  input wire logic       HOLD_GRANT_O, BUS_WR_O, DATA_IN_STROBE_O, INT_PENDING_O,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] RDATA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  property p_rd; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_wr; BUS_WR_O |-> !DATA_IN_STROBE_O; endproperty
  a_wr: assert property (p_wr) else $error("strobes clash");
  property p_len; $rose(BUSY_O) |-> BUSY_O [*4]; endproperty
  a_len: assert property (p_len) else $error("short op");
  property p_go; WR_I && ADDR_I == cfa_pkg::REG_CMD &&
    !(BUSY_O || HALTED_O || HOLD_GRANT_O || HOLD_I) |=> BUSY_O; endproperty
  a_go: assert property (p_go) else $error("op not started");
  property p_hlt; HALTED_O && !INT_I |=> HALTED_O && !BUSY_O; endproperty
  a_hlt: assert property (p_hlt) else $error("halt left");
  property p_int; HALTED_O && INT_I |=> INT_PENDING_O && !HALTED_O; endproperty
  a_int: assert property (p_int) else $error("int missed");
  property p_hq; HOLD_GRANT_O |-> !BUS_WR_O && !DATA_IN_STROBE_O; endproperty
  a_hq: assert property (p_hq) else $error("bus used in hold");
  property p_hf; HOLD_GRANT_O && !HOLD_I |-> ##[1:2] !HOLD_GRANT_O; endproperty
  a_hf: assert property (p_hf) else $error("hold kept");
endmodule
bind cfa_core cfa_props u_props (.CLK_I, .RST_I, .WR_I, .RD_I, .HOLD_I, .INT_I, .BUSY_O,
  .HALTED_O, .HOLD_GRANT_O, .BUS_WR_O, .DATA_IN_STROBE_O, .INT_PENDING_O, .ADDR_I, .RDATA_O);
`default_nettype wire

// ---- verif/cfa_mem_model.sv ----
// memory model on the far side of the bus
// assumes bus strobes clocked by clk_i
`default_nettype none
module cfa_mem_model (
  input  wire logic        clk_i, slow_i, wr_i, rd_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  output var logic         rdy_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  // registered ready stays synchronous; slow toggles it for wait states
  always @(posedge clk_i) begin
    rdy_o <= !slow_i || !rdy_o;
    if (wr_i) mem[addr_i[7:0]] <= data_i;
    if (rd_i) last <= data_o;
  end
  assign data_o = rd_i ? mem[addr_i[7:0]] : ~last;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 3);
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// bench: random add/sub, special ops, memory step, halt and hold
// assumes core, checker and memory model compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I = 0, RST_I = 1, WR_I = 0, RD_I = 0, HOLD_I = 0, INT_I = 0, slow = 0, h;
  logic [3:0] ADDR_I = 4'h0;
  logic [7:0] WDATA_I = 8'h00, RDATA_O, BUS_DATA_I, BUS_DATA_O, got, a, b;
  logic [15:0] BUS_ADDR_O;
  logic [8:0] r;
  logic BUS_WR_O, DATA_IN_STROBE_O, READY_I, HOLD_GRANT_O, INT_PENDING_O, HALTED_O, BUSY_O;
  logic io, oe;
  logic [1:0] wio = 2'h0;
  int errors = 0, n_checks = 0, cyc = 0, seed = 32'hEA1E;
  always #2 CLK_I = ~CLK_I;
  cfa_core u_dut (.CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .BUS_ADDR_O,
    .BUS_DATA_O, .BUS_DATA_OE_O(oe), .BUS_DATA_I, .BUS_WR_O, .BUS_IO_O(io), .DATA_IN_STROBE_O,
    .READY_I, .HOLD_I, .HOLD_GRANT_O, .INT_I, .INT_PENDING_O, .HALTED_O, .BUSY_O);
  cfa_mem_model u_mem (.clk_i(CLK_I), .slow_i(slow), .wr_i(BUS_WR_O), .rd_i(DATA_IN_STROBE_O),
    .addr_i(BUS_ADDR_O), .data_i(BUS_DATA_O), .data_o(BUS_DATA_I), .rdy_o(READY_I));
  function automatic logic [7:0] flags(input logic [8:0] v, input logic x);
    return {v[7], v[7:0] == 8'h00, 1'b0, x, 1'b0, ~^v[7:0], 1'b0, v[8]};
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] s, input string n);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [3:0] k, input logic [7:0] d);
    ADDR_I <= k;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_I) WR_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic rreg(input logic [3:0] k);
    ADDR_I <= k;
    RD_I <= 1'b1;
    @(posedge CLK_I) RD_I <= 1'b0;
    @(negedge CLK_I) got = RDATA_O;
    @(posedge CLK_I);
  endtask
  // busy is sampled mid-cycle so the launching edge has landed
  task automatic run(input logic [7:0] c);
    wreg(cfa_pkg::REG_CMD, c);
    do @(negedge CLK_I); while (BUSY_O !== 1'b0 && cyc < 9000);
    @(posedge CLK_I);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // kind of the latest bus write: {output enable, port cycle}
  always @(negedge CLK_I) if (BUS_WR_O) wio = {oe, io};
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 9000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(posedge CLK_I);
    for (int i = 0; i < 40; i++) begin
      a = i ? 8'($random(seed)) : 8'h80;
      b = i < 2 ? a : 8'($random(seed));
      wreg(cfa_pkg::REG_ACC, a);
      wreg(cfa_pkg::REG_B, b);
      run(i[0] ? 8'h20 : 8'h10);
      r = i[0] ? {1'b0, a} - b : {1'b0, a} + b;
      h = i[0] ? a[3:0] < b[3:0] : ({1'b0, a[3:0]} + b[3:0]) > 5'h0F;
      rreg(cfa_pkg::REG_ACC);
      chk(r[7:0], got, "acc");
      rreg(cfa_pkg::REG_FLAGS);
      chk(flags(r, h), got & 8'hD5, "flags");
    end
    run(8'h00);
    rreg(cfa_pkg::REG_FLAGS);
    chk(flags(r, h), got & 8'hD5, "idle flags");
    run(8'h98);
    rreg(cfa_pkg::REG_FLAGS);
    chk(8'h01, got & 8'h01, "carry set");
    run(8'hA0);
    rreg(cfa_pkg::REG_FLAGS);
    chk(8'h00, got & 8'h01, "carry flip");
    run(8'hA8);
    rreg(cfa_pkg::REG_ACC);
    chk(~r[7:0], got, "acc flip");
    $display("alu tests done");
    slow <= 1'b1;
    // carry is clear here, so jump-if-no-carry is taken; target bytes follow the opcode
    wreg(cfa_pkg::REG_PCL, 8'h10);
    wreg(cfa_pkg::REG_PCH, 8'h00);
    run(8'hCA);
    rreg(cfa_pkg::REG_PCL);
    chk(8'h33, got, "jump low");
    rreg(cfa_pkg::REG_PCH);
    chk(8'h36, got, "jump high");
    a = ~r[7:0];
    run(8'h80);
    rreg(cfa_pkg::REG_ACC);
    chk({a[6:0], a[7]}, got, "rotate");
    rreg(cfa_pkg::REG_FLAGS);
    chk({7'h00, a[7]}, got & 8'h01, "rotate carry");
    // port number is fetched from pc 0x3635, so the port cycle lands on 0x9F
    run(8'hC0);
    chk({a[6:0], a[7]}, u_mem.mem[8'h9F], "port out");
    chk(8'h03, {6'h00, wio}, "port strobe");
    wreg(cfa_pkg::REG_H, 8'h00);
    wreg(cfa_pkg::REG_L, a);
    b = u_mem.mem[a];
    run(8'h56);
    chk(b + 8'h01, u_mem.mem[a], "memory step");
    chk(8'h02, {6'h00, wio}, "memory strobe");
    run(8'hB0);
    rreg(cfa_pkg::REG_E);
    chk(a, got, "swap");
    run(8'h08);
    @(negedge CLK_I) chk(8'h01, {7'h00, HALTED_O}, "halt");
    @(posedge CLK_I) INT_I <= 1'b1;
    @(posedge CLK_I) INT_I <= 1'b0;
    @(negedge CLK_I) chk(8'h02, {6'h00, INT_PENDING_O, HALTED_O}, "wake");
    @(posedge CLK_I) HOLD_I <= 1'b1;
    repeat (3) @(negedge CLK_I);
    chk({7'h00, HOLD_GRANT_O}, 8'h01, "grant");
    @(posedge CLK_I) HOLD_I <= 1'b0;
    repeat (3) @(negedge CLK_I);
    chk({7'h00, HOLD_GRANT_O}, 8'h00, "release");
    $display("bus tests done");
    wrap_up();
  end
endmodule
`default_nettype wire
